// ==== rtl/vector_relocation_ext_irq.sv ====
// Interrupt front end: vector relocation with timed unlock, external and pin-change detection.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Block interrupts from unlock until after select write.
// - Without select write, block exactly four cycles.
// - Blocking never touches the global enable bit.
// - Boot vectors plus app lock: mute application code.
// - App vectors plus boot lock: mute boot code.
// - Select zero uses flash start, one boot start.
// - Unlock clears after four cycles or select write.
// - Boot start 0x3800/0x7800; boot fuse sets reset.
// - Pins trigger even when driven as outputs.
// - Group one pins 15:8, group zero 7:0.
// - Four masks choose contributing pin-change inputs.
// - Pin-change detection works without a clock.
// - External pin senses any change, falling, rising or low.
// - Level mode requests while pin stays low.
// - Edge detection runs on the I/O clock.
// - Low-level detection works without a clock.
// - I/O clock stops in all sleeps but idle.
// - Level gone before start-up: wake, no interrupt.
// - Inputs 30:16 and upper masks optional.
// - Sense code: low, change, fall, rise.
// - Flags set on trigger, cleared by vector or one.
// - Pulses over one clock period are caught.
module vector_relocation_ext_irq
	import irq_front_pkg::*;
#(
	parameter bit LARGE_PINS = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and fuses
	input wire logic ext_irq_zero_pin,
	input wire logic [30:0] pin_change_inputs,
	input wire fuse_t fuses,
	// Core status
	input wire logic sleeping,
	input wire logic sleep_idle,
	input wire logic startup_done,
	input wire logic exec_in_boot,
	input wire logic instr_done,
	input wire logic [4:0] vector_ack,
	// Core-facing requests
	output logic [4:0] irq_request,
	output logic irq_block,
	output logic [15:0] vector_base,
	output logic [15:0] reset_address,
	output logic wake,
	output logic io_clk_run
);

	// ****************************************
	// Register state
	// ****************************************
	logic [7:0] mcu_control_r;
	logic [2:0] unlock_cnt_r;
	logic hold_after_r;
	irq_cfg_t cfg_r;
	logic [4:0] flag_r;
	logic [7:0] pcmask_r [4];
	logic [1:0] ext_sync_r;
	logic ext_prev_r;
	logic [30:0] pc_sync0_r;
	logic [30:0] pc_sync1_r;
	logic [30:0] pc_prev_r;
	logic level_armed_r;
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	function automatic logic any_masked(input logic [7:0] chg, input logic [7:0] msk);
		return |(chg & msk);
	endfunction : any_masked

	// ****************************************
	// Bus decode
	// ****************************************
	wire do_write = aw_full_r && w_full_r && !s_axi_bvalid;
	wire wr_lane0 = w_strb_r[0];
	wire [7:0] wbyte = w_data_r[7:0];
	wire wr_mcu = do_write && wr_lane0 && aw_addr_r == MCU_CONTROL_OFS;
	wire wr_sense = do_write && wr_lane0 && aw_addr_r == SENSE_OFS;
	wire wr_enable = do_write && wr_lane0 && aw_addr_r == ENABLE_OFS;
	wire wr_flag = do_write && wr_lane0 && aw_addr_r == FLAG_OFS;
	wire wr_mask0 = do_write && wr_lane0 && aw_addr_r == MASK0_OFS;
	wire wr_mask1 = do_write && wr_lane0 && aw_addr_r == MASK1_OFS;
	wire wr_mask2 = do_write && wr_lane0 && aw_addr_r == MASK2_OFS && LARGE_PINS;
	wire wr_mask3 = do_write && wr_lane0 && aw_addr_r == MASK3_OFS && LARGE_PINS;
	wire wr_hit = aw_addr_r inside {MCU_CONTROL_OFS, SENSE_OFS, ENABLE_OFS, FLAG_OFS, MASK0_OFS, MASK1_OFS,
		MASK2_OFS, MASK3_OFS, STATUS_OFS};
	wire rd_hit = s_axi_araddr inside {MCU_CONTROL_OFS, SENSE_OFS, ENABLE_OFS, FLAG_OFS, MASK0_OFS, MASK1_OFS,
		MASK2_OFS, MASK3_OFS, STATUS_OFS};

	// ****************************************
	// Vector relocation unlock
	// ****************************************
	wire unlock_open = unlock_cnt_r != 3'h0;
	wire set_unlock = wr_mcu && wbyte[UNLOCK_BIT] && !unlock_open;
	wire sel_write = wr_mcu && unlock_open && !wbyte[UNLOCK_BIT];
	wire [2:0] cnt_nxt = set_unlock ? UNLOCK_CYCLES : sel_write ? 3'h0 :
		unlock_open ? unlock_cnt_r - 3'h1 : 3'h0;
	wire [7:0] mcu_nxt = {wbyte[DEBUG_OFF_BIT], 2'b00, wbyte[PULLUP_OFF_BIT], 2'b00,
		sel_write ? wbyte[SELECT_BIT] : mcu_control_r[SELECT_BIT], cnt_nxt != 3'h0};
	wire hold_nxt = sel_write ? 1'b1 : (hold_after_r && !instr_done);
	wire vec_in_boot = mcu_control_r[SELECT_BIT];
	wire section_mute = (vec_in_boot && fuses.app_section_lock_bit && !exec_in_boot) ||
		(!vec_in_boot && fuses.boot_section_lock_bit && exec_in_boot);
	wire [15:0] boot_start = fuses.large_flash ? BOOT_START_LARGE : BOOT_START_SMALL;

	// ****************************************
	// External interrupt detection
	// ****************************************
	wire io_tick = !sleeping || sleep_idle;
	wire ext_s = ext_sync_r[1];
	wire ext_edge = cfg_r.sense == SENSE_ANY ? ext_s != ext_prev_r :
		cfg_r.sense == SENSE_FALL ? ext_prev_r && !ext_s : cfg_r.sense == SENSE_RISE ? !ext_prev_r && ext_s : 1'b0;
	wire level_mode = cfg_r.sense == SENSE_LOW;
	// The raw pin drives the level wake path, so sleep without a clock still wakes.
	wire ext_level_low = level_mode && !ext_irq_zero_pin;
	wire level_req = level_mode && cfg_r.enable[EXT_BIT] && !ext_s && level_armed_r;

	// ****************************************
	// Pin-change detection
	// ****************************************
	wire [30:0] pc_live = LARGE_PINS ? pin_change_inputs : {15'h0000, pin_change_inputs[15:0]};
	wire [30:0] pc_chg = pc_sync1_r ^ pc_prev_r;
	wire [3:0] pc_hit = {any_masked({1'b0, pc_chg[30:24]}, pcmask_r[3]), any_masked(pc_chg[23:16], pcmask_r[2]),
		any_masked(pc_chg[15:8], pcmask_r[1]), any_masked(pc_chg[7:0], pcmask_r[0])};
	// Wake compares live pins with the last clocked sample, so it rises with the clock stopped.
	wire [30:0] pc_async = pc_live ^ pc_prev_r;
	wire [3:0] pc_wake = {any_masked({1'b0, pc_async[30:24]}, pcmask_r[3]), any_masked(pc_async[23:16], pcmask_r[2]),
		any_masked(pc_async[15:8], pcmask_r[1]), any_masked(pc_async[7:0], pcmask_r[0])};

	wire [4:0] trig = {pc_hit, ext_edge && io_tick};
	wire [4:0] clr = vector_ack | (wr_flag ? {wbyte[7:4], wbyte[0]} : 5'h00);
	wire [4:0] flag_nxt = ((flag_r & ~clr) | trig) & {4'hF, !level_mode};
	wire [4:0] req_nxt = {flag_r[4:1] & cfg_r.enable[4:1], (flag_r[0] && cfg_r.enable[0]) || level_req};

	wire [31:0] rd_val =
		s_axi_araddr == MCU_CONTROL_OFS ? {24'h000000, mcu_control_r} :
		s_axi_araddr == SENSE_OFS ? {30'h00000000, cfg_r.sense} :
		s_axi_araddr == ENABLE_OFS ? {24'h000000, cfg_r.enable[4:1], 3'b000, cfg_r.enable[0]} :
		s_axi_araddr == FLAG_OFS ? {24'h000000, flag_r[4:1], 3'b000, flag_r[0]} :
		s_axi_araddr == MASK0_OFS ? {24'h000000, pcmask_r[0]} :
		s_axi_araddr == MASK1_OFS ? {24'h000000, pcmask_r[1]} :
		s_axi_araddr == MASK2_OFS ? {24'h000000, pcmask_r[2]} :
		s_axi_araddr == MASK3_OFS ? {24'h000000, pcmask_r[3]} :
		s_axi_araddr == STATUS_OFS ? {27'h0000000, unlock_cnt_r, hold_after_r, ext_s} : 32'h00000000;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_full_r <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
	assign s_axi_wready = !w_full_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// ****************************************
	// Control and unlock
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mcu_control_r <= MCU_CONTROL_RST;
			unlock_cnt_r <= 3'h0;
			hold_after_r <= 1'b0;
			cfg_r <= '0;
			for (int i = 0; i < 4; i++) begin
				pcmask_r[i] <= 8'h00;
			end
		end else begin
			unlock_cnt_r <= cnt_nxt;
			hold_after_r <= hold_nxt;
			if (wr_mcu) begin
				mcu_control_r <= mcu_nxt;
			end else begin
				mcu_control_r[UNLOCK_BIT] <= cnt_nxt != 3'h0;
			end
			if (wr_sense) begin
				cfg_r.sense <= wbyte[1:0];
			end
			if (wr_enable) begin
				cfg_r.enable <= {wbyte[7:6] & {2{LARGE_PINS}}, wbyte[5:4], wbyte[0]};
			end
			if (wr_mask0) begin
				pcmask_r[0] <= wbyte;
			end
			if (wr_mask1) begin
				pcmask_r[1] <= wbyte;
			end
			if (wr_mask2) begin
				pcmask_r[2] <= wbyte;
			end
			if (wr_mask3) begin
				pcmask_r[3] <= {1'b0, wbyte[6:0]};
			end
		end
	end

	// ****************************************
	// Detection and outputs
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_sync_r <= 2'b11;
			ext_prev_r <= 1'b1;
			pc_sync0_r <= '0;
			pc_sync1_r <= '0;
			pc_prev_r <= '0;
			level_armed_r <= 1'b1;
			flag_r <= 5'h00;
			irq_request <= 5'h00;
			irq_block <= 1'b0;
			vector_base <= 16'h0000;
			reset_address <= 16'h0000;
			wake <= 1'b0;
			io_clk_run <= 1'b1;
		end else begin
			if (io_tick) begin
				ext_sync_r <= {ext_sync_r[0], ext_irq_zero_pin};
				ext_prev_r <= ext_s;
			end
			pc_sync0_r <= pc_live;
			pc_sync1_r <= pc_sync0_r;
			pc_prev_r <= pc_sync1_r;
			level_armed_r <= sleeping ? 1'b0 : (startup_done ? (level_armed_r || !ext_s) : level_armed_r);
			flag_r <= flag_nxt;
			irq_request <= req_nxt;
			irq_block <= set_unlock || cnt_nxt != 3'h0 || hold_nxt || section_mute;
			vector_base <= vec_in_boot ? boot_start : 16'h0000;
			reset_address <= fuses.boot_reset_fuse ? boot_start : 16'h0000;
			wake <= (|(pc_wake & cfg_r.enable[4:1])) || (ext_level_low && cfg_r.enable[EXT_BIT]);
			io_clk_run <= io_tick;
		end
	end

endmodule : vector_relocation_ext_irq

// ==== pkg/irq_front_pkg.sv ====
// Package: register map, field positions, reset values and timing for the interrupt front end.
package irq_front_pkg;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] MCU_CONTROL_OFS = 8'hD4;   // 0x35 index, byte address 4*0x35
	localparam logic [7:0] MCU_CONTROL_IDX = 8'h35;
	localparam logic [7:0] SENSE_OFS = 8'h00;
	localparam logic [7:0] ENABLE_OFS = 8'h04;
	localparam logic [7:0] FLAG_OFS = 8'h08;
	localparam logic [7:0] MASK0_OFS = 8'h0C;
	localparam logic [7:0] MASK1_OFS = 8'h10;
	localparam logic [7:0] MASK2_OFS = 8'h14;
	localparam logic [7:0] MASK3_OFS = 8'h18;
	localparam logic [7:0] STATUS_OFS = 8'h1C;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int UNLOCK_BIT = 0;
	localparam int SELECT_BIT = 1;
	localparam int PULLUP_OFF_BIT = 4;
	localparam int DEBUG_OFF_BIT = 7;
	localparam int EXT_BIT = 0;
	localparam int PCG_BIT = 4;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_ANY = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	localparam logic [15:0] BOOT_START_SMALL = 16'h3800;
	localparam logic [15:0] BOOT_START_LARGE = 16'h7800;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [1:0] sense;
		logic [4:0] enable;
	} irq_cfg_t;

	typedef struct packed {
		logic boot_section_lock_bit;
		logic app_section_lock_bit;
		logic boot_reset_fuse;
		logic large_flash;
	} fuse_t;

endpackage : irq_front_pkg

// ==== tb/irq_front_asserts.sv ====
// Checker of the interrupt front end ports, bound into the design.
`timescale 1ns/1ps
module irq_front_asserts
	import irq_front_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// Pins, fuses and core
	input wire logic ext_irq_zero_pin,
	input wire fuse_t fuses,
	input wire logic sleeping,
	input wire logic sleep_idle,
	input wire logic startup_done,
	input wire logic [4:0] irq_request,
	input wire logic irq_block,
	input wire logic [15:0] vector_base,
	input wire logic [15:0] reset_address,
	input wire logic io_clk_run
);
	// ********
	// Shadow of the last write and of the sense and enable registers
	// ********
	logic [7:0] wa_r, wd_r, sense_r, en_r;
	logic bv_r;
	wire applied = s_axi_bvalid && !bv_r;
	wire lock_off = !fuses.app_section_lock_bit && !fuses.boot_section_lock_bit;
	wire [15:0] boot_start = fuses.large_flash ? BOOT_START_LARGE : BOOT_START_SMALL;
	always_ff @(posedge aclk) begin
		bv_r <= s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
		if (!aresetn) begin
			sense_r <= 8'h00;
			en_r <= 8'h00;
		end else if (applied && wa_r == SENSE_OFS) begin
			sense_r <= wd_r;
		end else if (applied && wa_r == ENABLE_OFS) begin
			en_r <= wd_r;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence unlock_wr;
		applied && wa_r == MCU_CONTROL_OFS && wd_r[UNLOCK_BIT];
	endsequence
	sequence quiet_bus;
		(!s_axi_bvalid)[*6];
	endsequence
	a_unlock_block: assert property (unlock_wr |=> irq_block[*2]) else $error("no block after unlock");
	a_unlock_release: assert property (unlock_wr ##1 quiet_bus ##0 lock_off |-> !irq_block)
		else $error("block stuck");
	a_vector_legal: assert property (vector_base == 16'h0000 || vector_base == boot_start)
		else $error("bad vector base");
	a_reset_address: assert property ($past(aresetn) && $stable(fuses) |->
		reset_address == (fuses.boot_reset_fuse ? boot_start : 16'h0000)) else $error("bad reset address");
	a_io_clock_stop: assert property (sleeping && !sleep_idle |=> !io_clk_run) else $error("clock runs");
	a_io_clock_run: assert property (!sleeping |=> io_clk_run) else $error("clock stopped");
	a_level_request: assert property ((sense_r[1:0] == SENSE_LOW && en_r[EXT_BIT] && startup_done
		&& !ext_irq_zero_pin)[*6] |-> irq_request[EXT_BIT]) else $error("no level request");
	a_edge_request: assert property (sense_r[1:0] == SENSE_FALL && en_r[EXT_BIT] && io_clk_run
		&& $fell(ext_irq_zero_pin) |-> ##[1:8] irq_request[EXT_BIT]) else $error("no edge request");
endmodule : irq_front_asserts
bind vector_relocation_ext_irq irq_front_asserts chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .ext_irq_zero_pin, .fuses,
	.sleeping, .sleep_idle, .startup_done, .irq_request, .irq_block, .vector_base, .reset_address, .io_clk_run);

// ==== tb/core_model.sv ====
// Processor core model that retires instructions and vectors to pending requests.
`timescale 1ns/1ps
module core_model
	import irq_front_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench controls
	input wire logic gie,
	input wire logic stall,
	// Block side
	input wire logic [4:0] irq_request,
	input wire logic irq_block,
	output logic instr_done,
	output logic [4:0] vector_ack
);
	// The lowest pending request is serviced first; a stall freezes retirement.
	wire [4:0] pick = irq_request & (~irq_request + 5'h01);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_done <= 1'b0;
			vector_ack <= 5'h00;
		end else begin
			instr_done <= !stall && !instr_done;
			vector_ack <= (gie && !irq_block && instr_done) ? pick : 5'h00;
		end
	end
endmodule : core_model

// ==== tb/testbench.sv ====
// Testbench of the interrupt front end.
`timescale 1ns/1ps
module testbench
	import irq_front_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic ext_irq_zero_pin = 1'b1;
	logic [30:0] pin_change_inputs = 31'h00000000;
	fuse_t fuses = 4'h3;
	logic sleeping = 1'b0, sleep_idle = 1'b0, exec_in_boot = 1'b0, gie = 1'b0, stall = 1'b0, startup_done = 1'b1;
	logic instr_done, irq_block, wake, io_clk_run;
	logic [4:0] vector_ack, irq_request;
	logic [15:0] vector_base, reset_address;
	logic [30:0] pc_tbl [3] = '{31'h00000002, 31'h00000003, 31'h00008003};
	logic [1:0] pc_exp [3] = '{2'h0, 2'h1, 2'h3};
	int error_cnt = 0, checks = 0;
	always #4 aclk = ~aclk;
	vector_relocation_ext_irq dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_zero_pin,
		.pin_change_inputs, .fuses, .sleeping, .sleep_idle, .startup_done, .exec_in_boot, .instr_done,
		.vector_ack, .irq_request, .irq_block, .vector_base, .reset_address, .wake, .io_clk_run);
	core_model partner (.aclk, .aresetn, .gie, .stall, .irq_request, .irq_block, .instr_done, .vector_ack);
	// Readies are looked at on the falling edge, where they hold the value the next rising edge samples.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		// Bready stays up between writes, so back-to-back calls never drive it twice in one step.
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
		// Rready stays up between reads for the same reason.
	endtask : rd_reg
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic stop_test();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_reg(MCU_CONTROL_OFS);
		chk("control reset", d, 32'(MCU_CONTROL_RST));
		chk("reset address", 32'(reset_address), 32'(BOOT_START_LARGE));
		rd_reg(8'hFC);
		chk("unmapped response", 32'(r), 32'(AXI_SLVERR));
		wr_reg(MCU_CONTROL_OFS, 8'h01);
		repeat (8) @(posedge aclk);
		rd_reg(MCU_CONTROL_OFS);
		chk("unlock cleared", d, 32'h0);
		chk("block released", 32'(irq_block), 32'h0);
		stall <= 1'b1;
		wr_reg(MCU_CONTROL_OFS, 8'h01);
		wr_reg(MCU_CONTROL_OFS, 8'h02);
		repeat (10) @(posedge aclk);
		chk("block held", 32'(irq_block), 32'h1);
		chk("boot vectors", 32'(vector_base), 32'(BOOT_START_LARGE));
		stall <= 1'b0;
		repeat (6) @(posedge aclk);
		rd_reg(MCU_CONTROL_OFS);
		chk("select set", d, 32'h2);
		chk("block after instruction", 32'(irq_block), 32'h0);
		wr_reg(MCU_CONTROL_OFS, 8'h00);
		repeat (4) @(posedge aclk);
		chk("select kept", 32'(vector_base), 32'(BOOT_START_LARGE));
		fuses <= 4'h7;
		repeat (4) @(posedge aclk);
		chk("muted in application", 32'(irq_block), 32'h1);
		exec_in_boot <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("open in boot", 32'(irq_block), 32'h0);
		fuses <= 4'h3;
		sleeping <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("clock stopped in deep sleep", 32'(io_clk_run), 32'h0);
		sleep_idle <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("clock runs in idle", 32'(io_clk_run), 32'h1);
		sleeping <= 1'b0;
		wr_reg(ENABLE_OFS, 8'h31);
		for (int m = 0; m < 4; m++) begin
			wr_reg(SENSE_OFS, 8'(m));
			wr_reg(FLAG_OFS, 8'h01);
			ext_irq_zero_pin <= 1'b0;
			repeat (10) @(posedge aclk);
			chk("request after fall", 32'(irq_request[EXT_BIT]), 32'(m != 3));
			chk("wake on low level", 32'(wake), 32'(m == 0));
			wr_reg(FLAG_OFS, 8'h01);
			ext_irq_zero_pin <= 1'b1;
			repeat (10) @(posedge aclk);
			chk("request after rise", 32'(irq_request[EXT_BIT]), 32'(m == 1 || m == 3));
		end
		wr_reg(MASK0_OFS, 8'h01);
		wr_reg(MASK1_OFS, 8'h80);
		wr_reg(MASK3_OFS, 8'hFF);
		rd_reg(MASK3_OFS);
		chk("upper mask width", d, 32'h0000007F);
		for (int k = 0; k < 3; k++) begin
			pin_change_inputs <= pc_tbl[k];
			repeat (8) @(posedge aclk);
			chk("group requests", 32'(irq_request[2:1]), 32'(pc_exp[k]));
		end
		gie <= 1'b1;
		repeat (16) @(posedge aclk);
		chk("requests serviced", 32'(irq_request), 32'h0);
		wr_reg(SENSE_OFS, 8'h00);
		startup_done <= 1'b0;
		sleep_idle <= 1'b0;
		sleeping <= 1'b1;
		ext_irq_zero_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("wake on low in sleep", 32'(wake), 32'h1);
		sleeping <= 1'b0;
		repeat (6) @(posedge aclk);
		chk("no request before start-up", 32'(irq_request[EXT_BIT]), 32'h0);
		ext_irq_zero_pin <= 1'b1;
		repeat (4) @(posedge aclk);
		startup_done <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("no request after lost level", 32'(irq_request[EXT_BIT]), 32'h0);
		stop_test();
	end
endmodule : testbench
